// ---- design/fds_defs.svh ----
// register map, field positions, timing and the erased word value for the fan serial port
`ifndef FDS_DEFS_SVH
`define FDS_DEFS_SVH
`define FDS_TARGET_ADDR 7'h55
`define FDS_PARAM_BASE 8'h40
`define FDS_PARAM_FIRST 8'h41
`define FDS_PARAM_LAST 8'h54
`define FDS_REG_CTRL 8'hA1
`define FDS_REG_INDEX 8'hA2
`define FDS_REG_WDATA 8'hA3
`define FDS_REG_RDATA 8'hA4
`define FDS_REG_SPEED 8'hA5
`define FDS_CTRL_EN 0
`define FDS_CTRL_ER 1
`define FDS_CTRL_WR 2
`define FDS_CTRL_RD 3
`define FDS_NVM_WORDS 63
`define FDS_SPEED_FULL 10'h3FF
`define FDS_PROG_MS 12
`define FDS_CLK_KHZ 100000
`define FDS_PROG_CYCLES (`FDS_PROG_MS * `FDS_CLK_KHZ)
`define FDS_ERASED_WORD 16'h0000
`endif

// ---- design/fds_pkg.sv ----
// types shared by the fan serial port design
package fds_pkg;
  typedef enum logic [2:0] {
    FDS_IDLE,
    FDS_ADDR,
    FDS_REGPTR,
    FDS_WDATA,
    FDS_RDATA,
    FDS_ACK,
    FDS_RACK
  } fds_phase_e;
  typedef enum logic [1:0] {
    FDS_NV_IDLE,
    FDS_NV_ERASE,
    FDS_NV_WRITE
  } fds_nvm_e;
endpackage

// ---- design/fds_sync.sv ----
// two-flop synchroniser with edge outputs taken from the stable stage
module fds_sync (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

// ---- design/fds_nvm.sv ----
// 63 x 16 nonvolatile word store with timed erase and write
`include "fds_defs.svh"
module fds_nvm
  import fds_pkg::*;
#(
  parameter int PROG_CYCLES = `FDS_PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [3:0] ctrl,
  input wire logic [5:0] index,
  input wire logic [15:0] wdata,
  input wire logic [5:0] rindex,
  output logic [15:0] rdata,
  output logic busy
);
  logic [15:0] mem [0:`FDS_NVM_WORDS-1];
  fds_nvm_e state_q;
  logic [23:0] count_q;
  logic [5:0] idx_q;
  logic [15:0] data_q;
  // erase must win when both are set; otherwise the word would be corrupted
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= FDS_NV_IDLE;
      count_q <= 24'h000000;
      idx_q <= 6'h00;
      data_q <= 16'h0000;
    end else begin
      unique case (state_q)
        FDS_NV_IDLE: begin
          if (start && ctrl[`FDS_CTRL_EN] && index < 6'(`FDS_NVM_WORDS)) begin
            idx_q <= index;
            data_q <= wdata;
            count_q <= 24'(PROG_CYCLES - 1);
            if (ctrl[`FDS_CTRL_ER]) begin
              state_q <= FDS_NV_ERASE;
            end else if (ctrl[`FDS_CTRL_WR]) begin
              state_q <= FDS_NV_WRITE;
            end
          end
        end
        FDS_NV_ERASE, FDS_NV_WRITE: begin
          if (count_q == 24'h000000) begin
            state_q <= FDS_NV_IDLE;
          end else begin
            count_q <= count_q - 24'h000001;
          end
        end
      endcase
    end
  end
  // cells change only at the end of the pulse, so a read during it still sees the old word
  always_ff @(posedge mclk) begin
    if (state_q != FDS_NV_IDLE && count_q == 24'h000000) begin
      if (state_q == FDS_NV_ERASE) begin
        mem[idx_q] <= `FDS_ERASED_WORD;
      end else begin
        mem[idx_q] <= data_q;
      end
    end
  end
  assign rdata = (rindex < 6'(`FDS_NVM_WORDS)) ? mem[rindex] : 16'h0000;
  assign busy = state_q != FDS_NV_IDLE;
endmodule

// ---- design/fds_serial_port.sv ----
// two-wire serial target port of the fan driver: speed command, parameters and nvm access
`include "fds_defs.svh"
module fds_serial_port
  import fds_pkg::*;
#(
  parameter int PROG_CYCLES = `FDS_PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dutyPin,
  input wire logic tachOut,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  output logic serialMode,
  output logic [9:0] speedDemand,
  output logic nvmBusy
);
  logic sclLevel;
  logic sclRise;
  logic sclFall;
  logic sdaLevel;
  logic sdaRise;
  logic sdaFall;
  fds_sync uSyncScl (
    .mclk(mclk),
    .nrst(nrst),
    .pinIn(dutyPin),
    .level(sclLevel),
    .rise(sclRise),
    .fall(sclFall)
  );
  fds_sync uSyncSda (
    .mclk(mclk),
    .nrst(nrst),
    .pinIn(dataIn),
    .level(sdaLevel),
    .rise(sdaRise),
    .fall(sdaFall)
  );
  wire startCond = sdaFall & sclLevel;
  wire stopCond = sdaRise & sclLevel;

  fds_phase_e phase_q;
  fds_phase_e after_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic [7:0] regPtr_q;
  logic byteSel_q;
  logic [7:0] dataHi_q;
  logic [15:0] txWord_q;
  logic [15:0] ctrl_q;
  logic [15:0] index_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [9:0] speedCmd_q;
  logic [15:0] param_q [0:19];
  logic nvmStart_q;
  logic [15:0] nvmRdata;
  logic nvmBusyInt;
  logic serial_q;
  logic [9:0] dutyHigh_q;
  logic [9:0] dutyPeriod_q;
  logic [9:0] dutyMeas_q;
  logic oe_q;
  logic sdaDrv_q;
  logic writeStrobe_q;
  logic [15:0] writeVal_q;

  fds_nvm #(
    .PROG_CYCLES(PROG_CYCLES)
  ) uNvm (
    .mclk(mclk),
    .nrst(nrst),
    .start(nvmStart_q),
    .ctrl(ctrl_q[3:0]),
    .index(index_q[5:0]),
    .wdata(wdata_q),
    .rindex(regPtr_q < `FDS_PARAM_BASE ? regPtr_q[5:0] : index_q[5:0]),
    .rdata(nvmRdata),
    .busy(nvmBusyInt)
  );

  // read data for the current pointer
  logic [15:0] readVal;
  always_comb begin
    readVal = 16'h0000;
    if (regPtr_q < `FDS_PARAM_BASE) begin
      readVal = nvmRdata;
    end else if (regPtr_q >= `FDS_PARAM_FIRST && regPtr_q <= `FDS_PARAM_LAST) begin
      readVal = param_q[5'(regPtr_q - `FDS_PARAM_FIRST)];
    end else begin
      unique case (regPtr_q)
        `FDS_REG_CTRL: readVal = ctrl_q;
        `FDS_REG_INDEX: readVal = index_q;
        `FDS_REG_WDATA: readVal = wdata_q;
        `FDS_REG_RDATA: readVal = rdata_q;
        `FDS_REG_SPEED: readVal = {6'h00, speedCmd_q};
        default: readVal = 16'h0000;
      endcase
    end
  end

  // serial protocol engine; bits sampled on rising clock, driven after falling
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= FDS_IDLE;
      after_q <= FDS_IDLE;
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      regPtr_q <= 8'h00;
      byteSel_q <= 1'b0;
      dataHi_q <= 8'h00;
      txWord_q <= 16'h0000;
      sdaDrv_q <= 1'b1;
      oe_q <= 1'b0;
      writeStrobe_q <= 1'b0;
      writeVal_q <= 16'h0000;
    end else begin
      writeStrobe_q <= 1'b0;
      if (startCond) begin
        phase_q <= FDS_ADDR;
        bitCnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stopCond) begin
        phase_q <= FDS_IDLE;
        oe_q <= 1'b0;
      end else if (sclRise && phase_q != FDS_IDLE) begin
        if (phase_q == FDS_RACK) begin
          // master nack ends the read
          phase_q <= sdaLevel ? FDS_IDLE : FDS_RDATA;
          bitCnt_q <= 4'h0;
        end else if (phase_q != FDS_ACK && phase_q != FDS_RDATA) begin
          shift_q <= {shift_q[6:0], sdaLevel};
          bitCnt_q <= bitCnt_q + 4'h1;
        end else if (phase_q == FDS_RDATA) begin
          bitCnt_q <= bitCnt_q + 4'h1;
        end
      end else if (sclFall && phase_q != FDS_IDLE) begin
        oe_q <= 1'b0;
        if (phase_q == FDS_ACK) begin
          phase_q <= after_q;
          bitCnt_q <= 4'h0;
          if (after_q == FDS_RDATA) begin
            oe_q <= 1'b1;
            sdaDrv_q <= txWord_q[15];
            txWord_q <= {txWord_q[14:0], 1'b0};
          end
        end else if (phase_q == FDS_RDATA) begin
          if (bitCnt_q == 4'h8) begin
            phase_q <= FDS_RACK;
          end else begin
            oe_q <= 1'b1;
            sdaDrv_q <= txWord_q[15];
            txWord_q <= {txWord_q[14:0], 1'b0};
          end
        end else if (phase_q == FDS_RACK) begin
          oe_q <= 1'b1;
          sdaDrv_q <= txWord_q[15];
          txWord_q <= {txWord_q[14:0], 1'b0};
        end else if (bitCnt_q == 4'h8) begin
          unique case (phase_q)
            FDS_ADDR: begin
              if (shift_q[7:1] == `FDS_TARGET_ADDR) begin
                oe_q <= 1'b1;
                sdaDrv_q <= 1'b0;
                phase_q <= FDS_ACK;
                after_q <= shift_q[0] ? FDS_RDATA : FDS_REGPTR;
                txWord_q <= readVal;
              end else begin
                phase_q <= FDS_IDLE;
              end
            end
            FDS_REGPTR: begin
              regPtr_q <= shift_q;
              byteSel_q <= 1'b0;
              oe_q <= 1'b1;
              sdaDrv_q <= 1'b0;
              phase_q <= FDS_ACK;
              after_q <= FDS_WDATA;
            end
            FDS_WDATA: begin
              oe_q <= 1'b1;
              sdaDrv_q <= 1'b0;
              phase_q <= FDS_ACK;
              after_q <= FDS_WDATA;
              byteSel_q <= ~byteSel_q;
              if (!byteSel_q) begin
                dataHi_q <= shift_q; // msb first
              end else begin
                writeVal_q <= {dataHi_q, shift_q};
                writeStrobe_q <= 1'b1;
              end
            end
            default: phase_q <= FDS_IDLE;
          endcase
        end
      end
    end
  end

  // register file; only complete two-byte words are stored
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 16'h0000;
      index_q <= 16'h0000;
      wdata_q <= 16'h0000;
      speedCmd_q <= 10'h000;
      nvmStart_q <= 1'b0;
    end else begin
      nvmStart_q <= 1'b0;
      if (writeStrobe_q) begin
        unique case (regPtr_q)
          `FDS_REG_CTRL: begin
            ctrl_q <= writeVal_q;
            nvmStart_q <= ~nvmBusyInt;
          end
          `FDS_REG_INDEX: index_q <= writeVal_q;
          `FDS_REG_WDATA: wdata_q <= writeVal_q;
          `FDS_REG_SPEED: speedCmd_q <= writeVal_q[9:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (writeStrobe_q && regPtr_q >= `FDS_PARAM_FIRST && regPtr_q <= `FDS_PARAM_LAST) begin
      param_q[5'(regPtr_q - `FDS_PARAM_FIRST)] <= writeVal_q;
    end
  end

  // read latch follows the selected word while read mode is set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (ctrl_q[`FDS_CTRL_RD]) begin
      rdata_q <= nvmRdata;
    end
  end

  // any recognised serial command leaves duty mode for good until reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      serial_q <= 1'b0;
    end else if (phase_q == FDS_ACK && !serial_q) begin
      serial_q <= 1'b1;
    end
  end

  // duty measured over 1023 mclk windows; a pin high for a whole window gives full demand
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dutyHigh_q <= 10'h000;
      dutyPeriod_q <= 10'h000;
      dutyMeas_q <= 10'h000;
    end else if (dutyPeriod_q == `FDS_SPEED_FULL - 10'h001) begin
      dutyPeriod_q <= 10'h000;
      dutyHigh_q <= 10'h000;
      dutyMeas_q <= dutyHigh_q + {9'h000, sclLevel};
    end else begin
      dutyPeriod_q <= dutyPeriod_q + 10'h001;
      dutyHigh_q <= dutyHigh_q + {9'h000, sclLevel};
    end
  end

  // speed output pin shares the data line: tach drive only in duty mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dataOut <= 1'b1;
      dataOe <= 1'b0;
      serialMode <= 1'b0;
      speedDemand <= 10'h000;
      nvmBusy <= 1'b0;
    end else begin
      serialMode <= serial_q;
      nvmBusy <= nvmBusyInt;
      if (oe_q) begin
        dataOut <= sdaDrv_q;
        dataOe <= ~sdaDrv_q;
      end else begin
        dataOut <= tachOut;
        dataOe <= ~serial_q & ~tachOut;
      end
      // ignoring the duty pin in serial mode; zero until speed register written
      speedDemand <= serial_q ? speedCmd_q : dutyMeas_q;
    end
  end
endmodule

// ---- sim/fds_host.sv ----
// two-wire bus host model driving the fan port clock and data pins
module fds_host (
  input wire logic mclk,
  input wire logic dataOe,
  output logic scl,
  output logic sdaLow,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nak;
  // pull-up on the shared line, so a released line reads high
  assign sda = !(dataOe || sdaLow);
  initial begin
    scl = 1'b0; // both pins held low through power-up
    sdaLow = 1'b1;
    nak = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic hold(input logic c, input logic d, input int n);
    scl <= c;
    sdaLow <= !d;
    hc(n);
  endtask
  // 8 cycles low and 8 high: slower than the port's fastest to keep margin
  task automatic bitw(input logic b);
    sdaLow <= !b;
    hc(4);
    scl <= 1'b1;
    hc(8);
    scl <= 1'b0;
    hc(4);
  endtask
  task automatic bitr(output logic b);
    sdaLow <= 1'b0;
    hc(4);
    scl <= 1'b1;
    hc(4);
    b = sda;
    hc(4);
    scl <= 1'b0;
    hc(4);
  endtask
  task automatic sta();
    nak = 1'b0;
    sdaLow <= 1'b1;
    hc(8);
    scl <= 1'b0;
    hc(4);
  endtask
  task automatic sto();
    sdaLow <= 1'b1;
    hc(4);
    scl <= 1'b1;
    hc(8);
    sdaLow <= 1'b0;
    hc(8);
  endtask
  task automatic sendb(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) bitw(v[i]); // msb first
    bitr(a);
    nak = nak | a;
  endtask
  task automatic wreg(input logic [6:0] dev, input logic [7:0] ra, input logic [15:0] d);
    sta();
    sendb({dev, 1'b0});
    sendb(ra);
    sendb(d[15:8]);
    sendb(d[7:0]);
    sto();
  endtask
  task automatic rreg(input logic [7:0] ra, output logic [15:0] d);
    sta();
    sendb(8'hAA);
    sendb(ra);
    sto(); // pointer set ends with its own stop
    sta();
    sendb(8'hAB);
    for (int i = 15; i >= 0; i--) begin
      bitr(d[i]);
      if (i == 8 || i == 0) bitw(i == 0); // ack high byte, nack low byte
    end
    sto();
  endtask
endmodule

// ---- sim/fds_serial_port_chk.sv ----
// pin-level assertions for the fan serial port
module fds_serial_port_chk #(
  parameter int PROG_CYCLES = 60
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dutyPin,
  input wire logic tachOut,
  input wire logic dataIn,
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic serialMode,
  input wire logic [9:0] speedDemand,
  input wire logic nvmBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // pulse length is far beyond a repetition count, so it is counted here
  logic [23:0] busyLen_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busyLen_q <= 24'h000000;
    end else if (nvmBusy) begin
      busyLen_q <= busyLen_q + 24'h000001;
    end else begin
      busyLen_q <= 24'h000000;
    end
  end
  sequence s_sclHigh;
    (serialMode && dutyPin)[*8];
  endsequence
  sequence s_busyHold;
    nvmBusy[*8];
  endsequence
  property p_rstIdle;
    $rose(nrst) |-> !serialMode && !dataOe && !nvmBusy;
  endproperty
  property p_modeSticky;
    serialMode |=> serialMode;
  endproperty
  property p_pullLow;
    dataOe |-> !dataOut;
  endproperty
  property p_busyHold;
    $rose(nvmBusy) |-> s_busyHold;
  endproperty
  property p_busyCause;
    $rose(nvmBusy) |-> serialMode;
  endproperty
  // commits land a few cycles after a clock fall, never deep in a high phase
  property p_speedHold;
    s_sclHigh |=> $stable(speedDemand);
  endproperty
  property p_ackLow;
    serialMode && $rose(dataOe) |-> !dutyPin;
  endproperty
  property p_busyLen;
    $fell(nvmBusy) |-> busyLen_q == 24'(PROG_CYCLES);
  endproperty
  property p_bitStable;
    serialMode && $rose(dutyPin) |=> $stable(dataOe)[*6];
  endproperty
  a_rstIdle: assert property (p_rstIdle) else $error("outputs not idle after reset");
  a_modeSticky: assert property (p_modeSticky) else $error("serial mode dropped");
  a_pullLow: assert property (p_pullLow) else $error("data driven high while enabled");
  a_busyHold: assert property (p_busyHold) else $error("program pulse too short");
  a_busyCause: assert property (p_busyCause) else $error("program pulse outside serial mode");
  a_speedHold: assert property (p_speedHold) else $error("speed changed without transfer");
  a_ackLow: assert property (p_ackLow) else $error("data drive began with clock high");
  a_bitStable: assert property (p_bitStable) else $error("data moved while clock high");
  a_busyLen: assert property (p_busyLen) else $error("program pulse length wrong");
endmodule
bind fds_serial_port fds_serial_port_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (.mclk(mclk), .nrst(nrst),
  .dutyPin(dutyPin), .tachOut(tachOut), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
  .serialMode(serialMode), .speedDemand(speedDemand), .nvmBusy(nvmBusy));

// ---- sim/fds_serial_port_tb.sv ----
// self-checking bench for the fan serial port
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module fds_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 60;
  logic mclk, nrst, tachOut, dataOut, dataOe, serialMode, nvmBusy, scl, sdaLow, sda;
  logic [9:0] speedDemand;
  logic [15:0] rd;
  logic [9:0] spd [3] = '{10'h3FF, 10'h066, 10'h000};
  logic [5:0] wix [2] = '{6'h05, 6'h3E};
  logic [15:0] wdat [2] = '{16'h0105, 16'hA5A5};
  int error_cnt = 0;
  int n_checks = 0;
  fds_host host (.mclk(mclk), .dataOe(dataOe), .scl(scl), .sdaLow(sdaLow), .sda(sda));
  fds_serial_port #(.PROG_CYCLES(PROG)) dut (.mclk(mclk), .nrst(nrst), .dutyPin(scl), .tachOut(tachOut),
    .dataIn(sda), .dataOut(dataOut), .dataOe(dataOe), .serialMode(serialMode), .speedDemand(speedDemand),
    .nvmBusy(nvmBusy));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for the program pulse, which the host must sit out
  task automatic nvm_wait();
    int i;
    `CHK(nvmBusy, 1'b1)
    i = 0;
    while (nvmBusy === 1'b1 && i < 2000) begin
      @(posedge mclk);
      i++;
    end
    if (i >= 2000) begin
      error_cnt++;
      test_done();
    end
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    tachOut = 1'b1;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    host.hc(4);
    `CHK(serialMode, 1'b0)
    host.hold(1'b1, 1'b0, 2200);
    `CHK(speedDemand, 10'h3FF)
    host.hold(1'b0, 1'b0, 2200);
    `CHK(speedDemand, 10'h000)
    tachOut <= 1'b0;
    host.hc(6);
    `CHK(dataOe, 1'b1)
    `CHK(dataOut, 1'b0)
    tachOut <= 1'b1;
    host.hold(1'b1, 1'b1, 20);
    `CHK(dataOe, 1'b0)
    `CHK(dataOut, 1'b1)
    host.wreg(7'h54, 8'hA5, 16'h0200);
    `CHK(host.nak, 1'b1)
    `CHK(serialMode, 1'b0)
    host.wreg(7'h55, 8'h41, 16'h1234);
    `CHK(host.nak, 1'b0)
    `CHK(serialMode, 1'b1)
    `CHK(speedDemand, 10'h000)
    host.wreg(7'h55, 8'h54, 16'hBEEF);
    host.wreg(7'h55, 8'h60, 16'hFFFF); // unmapped, dropped but acked
    host.rreg(8'h41, rd);
    `CHK(rd, 16'h1234)
    host.rreg(8'h54, rd);
    `CHK(rd, 16'hBEEF)
    host.rreg(8'h60, rd);
    `CHK(rd, 16'h0000)
    foreach (spd[i]) begin
      host.wreg(7'h55, 8'hA5, {6'h00, spd[i]});
      host.hc(4);
      `CHK(speedDemand, spd[i])
    end
    // one word at a time, erased before written
    foreach (wix[i]) begin
      host.wreg(7'h55, 8'hA2, {10'h000, wix[i]});
      host.wreg(7'h55, 8'hA3, 16'h0000);
      host.wreg(7'h55, 8'hA1, 16'h0003); // erase, upper bits zero
      nvm_wait();
      host.rreg({2'b00, wix[i]}, rd);
      `CHK(rd, 16'h0000)
      host.wreg(7'h55, 8'hA3, wdat[i]);
      host.wreg(7'h55, 8'hA1, 16'h0005);
      nvm_wait();
      host.wreg(7'h55, 8'hA1, 16'h0008);
      host.rreg(8'hA4, rd);
      `CHK(rd, wdat[i])
      host.rreg({2'b00, wix[i]}, rd);
      `CHK(rd, wdat[i])
    end
    host.rreg(8'h05, rd);
    `CHK(rd, 16'h0105)
    host.rreg(8'hA1, rd);
    `CHK(rd, 16'h0008)
    host.rreg(8'hA2, rd);
    `CHK(rd, 16'h003E)
    host.rreg(8'hA3, rd);
    `CHK(rd, 16'hA5A5)
    // mid-run reset with the clock pin left high: back to duty mode at full demand
    nrst <= 1'b0;
    host.hc(3);
    nrst <= 1'b1;
    host.hc(3);
    `CHK(serialMode, 1'b0)
    `CHK(speedDemand, 10'h000)
    host.hc(1100);
    `CHK(speedDemand, 10'h3FF)
    test_done();
  end
endmodule
